// *** rism_pkg.sv ***
// package for the radio interrupt flag and supply monitor block
// assumes an 8-bit register port with a 9-bit address
package rism_pkg;

  // register addresses
  localparam logic [8:0] RISM_ADDR_PEND_EXTRA = 9'h0BF;
  localparam logic [8:0] RISM_ADDR_PEND = 9'h14F;
  localparam logic [8:0] RISM_ADDR_VREG = 9'h150;
  localparam logic [8:0] RISM_ADDR_BATTERY_MONITOR_CONTROL = 9'h151;
  localparam logic [8:0] RISM_ADDR_MASK = 9'h14E;
  localparam logic [8:0] RISM_ADDR_MASK_EXTRA = 9'h0BE;

  // regulator field positions
  localparam int RISM_VREG_AEXT = 7;
  localparam int RISM_VREG_AOK = 6;
  localparam int RISM_VREG_ATRIM = 4;
  localparam int RISM_VREG_DEXT = 3;
  localparam int RISM_VREG_DOK = 2;
  localparam int RISM_VREG_DTRIM = 0;

  // battery monitor field positions
  localparam int RISM_BATTERY_LOW_FLAG = 7;
  localparam int RISM_BAT_EN = 6;
  localparam int RISM_BAT_OK = 5;
  localparam int RISM_BAT_HR = 4;
  localparam int RISM_BAT_VTH = 0;

  // reset values and masks
  localparam logic [3:0] RISM_VTH_RST = 4'h2;
  localparam logic [7:0] RISM_EXTRA_MASK = 8'h1F;

  // index of the battery request in the service-ack vector
  localparam int RISM_ACK_BAT = 13;

  // software-visible register state
  typedef struct packed {
    logic [7:0] pend;
    logic [4:0] pend_x;
    logic [7:0] mask;
    logic [4:0] mask_x;
    logic aext;
    logic [1:0] atrim;
    logic dext;
    logic [1:0] dtrim;
    logic battery_low_flag;
    logic bat_en;
    logic bat_hr;
    logic [3:0] bat_vth;
    logic [7:0] rdata;
  } rism_state_t;

  // analog controls handed to the regulators and monitor
  typedef struct packed {
    logic analog_reg_off;
    logic [1:0] analog_supply_trim;
    logic [1:0] digital_supply_trim;
    logic battery_range_select;
    logic [3:0] battery_threshold_code;
  } rism_ana_t;

endpackage

// *** rism_core.sv ***
// register file for radio interrupt flags, regulators and battery monitor
// assumes events, ack strobes and analog status are synchronous one-bit
// signals; events and acks are one-cycle pulses
//
// What this block does
// - eight radio event flags at 0x14F, bits 7..0, reset zero
// - writing one clears a set flag; writing zero leaves it
// - a flag clears itself when its service routine starts
// - extra flag register 0xBF: filter matches bits 4..1, tx start bit 0
// - external analog supply bit turns internal analog regulator off
// - analog settled reads one when stable or external supply selected
// - analog trim bits 5:4 pick 1.80/1.75/1.84/1.88 V
// - external digital supply bit drives no analog output, only digital settled
// - digital settled reads one when stable or external bit set
// - digital trim bits 1:0 use the same voltage codes
// - battery low flag bit 7, cleared by writing one
// - battery enable bit 6 gates the battery interrupt
// - battery ok reads one above threshold, zero below
// - threshold code bits 3:0 reset 2, range bit 4, both writable
// - battery request only when flag and enable both one
// - radio request needs flag and enable; enables reset zero
// - range bit zero picks low range, one picks high
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module rism_core
  import rism_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_radio_event,
  input wire logic [4:0] i_radio_event_extra,
  input wire logic i_battery_below,
  input wire logic i_analog_stable,
  input wire logic i_digital_stable,
  input wire logic [13:0] i_service_ack,
  output logic [13:0] o_irq_req,
  output logic o_irq,
  output rism_ana_t o_ana
);

  rism_state_t s_q;
  rism_state_t s_d;
  logic bat_ok;
  logic aok;
  logic dok;
  logic bat_fall;
  logic below_q;

  // -------------------------------------------------------------
  // status terms
  // -------------------------------------------------------------
  // battery ok sense
  assign bat_ok = ~i_battery_below;
  assign aok = i_analog_stable | s_q.aext;
  assign dok = i_digital_stable | s_q.dext;
  // battery flag sets on the rising edge of the below-threshold input
  assign bat_fall = i_battery_below & ~below_q;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (i_wr && i_addr == RISM_ADDR_PEND)
    begin
      s_d.pend = s_q.pend & ~i_wdata;
    end
    if (i_wr && i_addr == RISM_ADDR_PEND_EXTRA)
    begin
      s_d.pend_x = s_q.pend_x & ~i_wdata[4:0];
    end
    if (i_wr && i_addr == RISM_ADDR_MASK)
    begin
      s_d.mask = i_wdata;
    end
    if (i_wr && i_addr == RISM_ADDR_MASK_EXTRA)
    begin
      s_d.mask_x = i_wdata[4:0];
    end
    if (i_wr && i_addr == RISM_ADDR_VREG)
    begin
      s_d.aext = i_wdata[RISM_VREG_AEXT];
      s_d.atrim = i_wdata[RISM_VREG_ATRIM +: 2];
      s_d.dext = i_wdata[RISM_VREG_DEXT];
      s_d.dtrim = i_wdata[RISM_VREG_DTRIM +: 2];
    end
    if (i_wr && i_addr == RISM_ADDR_BATTERY_MONITOR_CONTROL)
    begin
      // write one clears the battery flag
      if (i_wdata[RISM_BATTERY_LOW_FLAG])
      begin
        s_d.battery_low_flag = 1'b0;
      end
      s_d.bat_en = i_wdata[RISM_BAT_EN];
      s_d.bat_hr = i_wdata[RISM_BAT_HR];
      s_d.bat_vth = i_wdata[RISM_BAT_VTH +: 4];
    end
    s_d.pend = s_d.pend & ~i_service_ack[7:0];
    s_d.pend_x = s_d.pend_x & ~i_service_ack[12:8];
    if (i_service_ack[RISM_ACK_BAT])
    begin
      s_d.battery_low_flag = 1'b0;
    end
    // events set flags; set wins over any clear
    s_d.pend = s_d.pend | i_radio_event;
    s_d.pend_x = s_d.pend_x | i_radio_event_extra;
    if (bat_fall)
    begin
      s_d.battery_low_flag = 1'b1;
    end
    // read data returned the cycle after the strobe
    if (i_rd)
    begin
      case (i_addr)
        RISM_ADDR_PEND: s_d.rdata = s_q.pend;
        RISM_ADDR_PEND_EXTRA: s_d.rdata = {3'b000, s_q.pend_x};
        RISM_ADDR_MASK: s_d.rdata = s_q.mask;
        RISM_ADDR_MASK_EXTRA: s_d.rdata = {3'b000, s_q.mask_x};
        RISM_ADDR_VREG: s_d.rdata = {s_q.aext, aok, s_q.atrim,
                                     s_q.dext, dok, s_q.dtrim};
        RISM_ADDR_BATTERY_MONITOR_CONTROL: s_d.rdata = {s_q.battery_low_flag, s_q.bat_en, bat_ok,
                                       s_q.bat_hr, s_q.bat_vth};
        default: s_d.rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.bat_vth <= RISM_VTH_RST;
      below_q <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
      below_q <= i_battery_below;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign o_rdata = s_q.rdata;
  assign o_irq_req[12:0] = {s_q.pend_x & s_q.mask_x, s_q.pend & s_q.mask};
  assign o_irq_req[RISM_ACK_BAT] = s_q.battery_low_flag & s_q.bat_en;
  assign o_irq = |o_irq_req;
  // regulator off follows the select bit
  assign o_ana.analog_reg_off = s_q.aext;
  assign o_ana.analog_supply_trim = s_q.atrim;
  assign o_ana.digital_supply_trim = s_q.dtrim;
  // range select goes to the comparator
  assign o_ana.battery_range_select = s_q.bat_hr;
  assign o_ana.battery_threshold_code = s_q.bat_vth;

endmodule

// *** rism_chk.sv ***
// checker for the rism_core register and request ports
// assumes strobes are one cycle and never both high
`timescale 1ns/1ps
module rism_chk
  import rism_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_radio_event,
  input wire logic i_battery_below,
  input wire logic i_analog_stable,
  input wire logic [13:0] i_service_ack,
  input wire logic [13:0] o_irq_req,
  input wire logic o_irq,
  input wire rism_ana_t o_ana
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_irq_is_or: assert property (o_irq == |o_irq_req)
    else $error("irq level differs from request or");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_w1c_clear: assert property (i_wr && i_addr == RISM_ADDR_PEND &&
    i_wdata[0] && !i_radio_event[0] |=> !o_irq_req[0])
    else $error("write one left flag set");
  a_ack_clear: assert property (i_service_ack[0] &&
    !i_radio_event[0] |=> !o_irq_req[0])
    else $error("service ack left flag set");
  a_ana_write: assert property (i_wr && i_addr == RISM_ADDR_VREG |=>
    {o_ana[9:5]} == {$past(i_wdata[7]), $past(i_wdata[5:4]),
    $past(i_wdata[1:0])}) else $error("regulator controls not written");
  a_thr_write: assert property (i_wr && i_addr == RISM_ADDR_BATTERY_MONITOR_CONTROL |=>
    o_ana[4:0] == $past(i_wdata[4:0])) else $error("threshold not written");
  a_bat_ok: assert property (i_rd && i_addr == RISM_ADDR_BATTERY_MONITOR_CONTROL |=>
    o_rdata[5] == !$past(i_battery_below)) else $error("battery ok wrong");
  a_extra_rsvd: assert property (i_rd && i_addr == RISM_ADDR_PEND_EXTRA
    |=> o_rdata[7:5] == 3'h0) else $error("reserved bits not zero");
  a_aok_read: assert property (i_rd && i_addr == RISM_ADDR_VREG |=>
    o_rdata[6] == ($past(i_analog_stable) | $past(o_ana.analog_reg_off)))
    else $error("analog settled bit wrong");
  c_irq: cover property (o_irq);
  c_bat: cover property (o_irq_req[13]);
  c_w1c: cover property (i_wr && i_addr == RISM_ADDR_PEND);
endmodule

bind rism_core rism_chk u_chk (.*);

// *** rism_core_tb.sv ***
// bench for rism_core: bus tasks and one task per scenario
// assumes the register port and addresses of rism_pkg
`timescale 1ns/1ps
module rism_core_tb
  import rism_pkg::*;
;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, below = 0, ast = 0, dst = 0;
  logic [8:0] addr = 0;
  logic [7:0] wd = 0, ev = 0, rdat;
  logic [4:0] evx = 0;
  logic [13:0] ack = 0, req;
  logic irq;
  rism_ana_t ana;
  int failures = 0, num_checks = 0;
  always #10 clk = ~clk;
  rism_core uut (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_radio_event(ev), .i_radio_event_extra(evx),
    .i_battery_below(below), .i_analog_stable(ast),
    .i_digital_stable(dst), .i_service_ack(ack), .o_irq_req(req),
    .o_irq(irq), .o_ana(ana));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task chk(input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrt(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
    // let the register update settle before any caller compares outputs
    #1;
  endtask
  // read data is only valid the cycle after the strobe
  task rdc(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(rdat, e);
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_flags;
    @(posedge clk) ev <= 8'h81;
    @(posedge clk) ev <= 0;
    rdc(RISM_ADDR_PEND, 8'h81);
    chk(irq, 0);
    wrt(RISM_ADDR_MASK, 8'hFF);
    chk(req, 14'h0081);
    wrt(RISM_ADDR_PEND, 8'h01);
    rdc(RISM_ADDR_PEND, 8'h80);
    @(posedge clk) ack <= 14'h0080;
    @(posedge clk) ack <= 0;
    rdc(RISM_ADDR_PEND, 8'h00);
    $display("flags done");
  endtask
  task t_extra;
    @(posedge clk) evx <= 5'h1F;
    @(posedge clk) evx <= 0;
    wrt(RISM_ADDR_MASK_EXTRA, 8'hFF);
    rdc(RISM_ADDR_PEND_EXTRA, 8'h1F);
    chk(req[12:8], 5'h1F);
    wrt(RISM_ADDR_PEND_EXTRA, 8'hFF);
    rdc(RISM_ADDR_PEND_EXTRA, 8'h00);
    rdc(9'h100, 8'h00);
    $display("extra done");
  endtask
  task t_vreg;
    wrt(RISM_ADDR_VREG, 8'hB9);
    rdc(RISM_ADDR_VREG, 8'hFD);
    chk(ana, {1'b1, 2'h3, 2'h1, 1'b0, 4'h2});
    ast <= 1;
    wrt(RISM_ADDR_VREG, 8'h00);
    rdc(RISM_ADDR_VREG, 8'h40);
    $display("vreg done");
  endtask
  task t_bat;
    wrt(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'h5F);
    below <= 1;
    rdc(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'hDF);
    chk(req[13], 1);
    wrt(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'h9F);
    rdc(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'h1F);
    below <= 0;
    @(posedge clk) below <= 1;
    rdc(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'h9F);
    chk(req[13], 0);
    $display("battery done");
  endtask
  initial
  begin
    #200000;
    failures++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    rdc(RISM_ADDR_BATTERY_MONITOR_CONTROL, 8'h22);
    rdc(RISM_ADDR_PEND, 8'h00);
    $display("reset done");
    t_flags;
    t_extra;
    t_vreg;
    t_bat;
    results;
  end
endmodule
